/* File: sim/sfo_host_model.sv */
// spi host controller model for the serial flash link
`timescale 1ns/1ns
module sfo_host_model (
   output logic sck, // link clock, still between frames
   output logic cs_n, // chip select, low active
   output logic mosi, // data toward the device
   input wire logic miso, // data from the device
   input wire logic miso_oe // device drives miso
);
   logic [7:0] rx_q[$]; // bytes read back
   logic oe_seen; // device drove during the frame
   initial begin
      sck = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b0;
      oe_seen = 1'b0;
   end
   ///////////////////////////////////////////////////////////////
   // one frame: opcode, pre bits of address and dummy, nrd read bits;
   // total time is a multiple of 4 ns so system clock phase is kept
   task automatic frame(input logic [7:0] op, input logic [23:0] addr,
      input int pre, input int nrd);
      logic [39:0] sh;
      logic [7:0] b;
      sh = {op, addr, 8'h00};
      b = 8'h00;
      rx_q.delete();
      oe_seen = 1'b0;
      #1 cs_n = 1'b0;
      for (int i = 0; i < 8 + pre + nrd; i++) begin
         // released data line toggles so no stale level is read
         if (i < 40) mosi = sh[39 - i];
         else mosi = ~mosi;
         #80 sck = 1'b1;
         if (i >= 8 + pre) begin
            b = {b[6:0], miso};
            if (miso_oe === 1'b1) oe_seen = 1'b1;
            if ((i - 8 - pre) % 8 == 7) rx_q.push_back(b);
         end
         #80 sck = 1'b0;
      end
      #80 cs_n = 1'b1;
      mosi = ~mosi;
      #159;
   endtask
endmodule // sfo_host_model

/* File: sim/sfo_properties.sv */
// port checks for the sfdp read and otp erase block
`timescale 1ns/1ns
module sfo_properties
   import sfo_pkg::*;
(
   input wire logic SYS_CLK, // system clock
   input wire logic SYS_RST, // sync reset
   input wire logic SPI_SCK, // link clock
   input wire logic SPI_CS_N, // chip select
   input wire logic SPI_MOSI, // data in
   input wire logic SPI_MISO, // data out
   input wire logic SPI_MISO_OE, // out enable
   input wire logic ARRAY_BUSY, // array busy
   input wire logic [23:0] ARR_ADDR, // array address
   input wire logic ARR_OTP_HIT, // otp hit
   input wire logic OTP_MODE, // otp mode
   input wire logic ERASE_REQ, // erase pulse
   input wire sfo_erase_req_t ERASE_INFO, // erase target
   input wire logic ERASE_REFUSED, // refusal pulse
   input wire logic SFDP_ACTIVE // stream running
);
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (SYS_RST);
   // otp window decode, the hit output lags it by one cycle
   wire logic hit_exp = OTP_MODE && (ARR_ADDR >= 24'h0FF000)
      && (ARR_ADDR <= 24'h0FF1FF);
   ///////////////////////////////////////////////////////////////
   AST_CS_STOPS: assert property (SPI_CS_N |-> !SPI_MISO_OE && !SPI_MISO)
      else $error("output driven while deselected");
   AST_OTP_HIT: assert property (hit_exp |=> ARR_OTP_HIT)
      else $error("otp window access not flagged");
   AST_OTP_MISS: assert property (!hit_exp |=> !ARR_OTP_HIT)
      else $error("otp hit outside window or mode");
   AST_ERASE_EXCL: assert property (!(ERASE_REQ && ERASE_REFUSED))
      else $error("erase taken and refused together");
   AST_REQ_PULSE: assert property (ERASE_REQ |=> !ERASE_REQ)
      else $error("erase start longer than one cycle");
   AST_REF_PULSE: assert property ($rose(ERASE_REFUSED)
      |=> $fell(ERASE_REFUSED))
      else $error("refusal longer than one cycle");
   AST_OTP_SECTOR: assert property (ERASE_REQ && ERASE_INFO.otp
      |-> ERASE_INFO.kind == EK_SECTOR
      && ERASE_INFO.addr[23:12] == 12'h0FF)
      else $error("otp erased by other than sector erase");
   AST_OTP_NO_CHIP: assert property (ERASE_REQ && OTP_MODE
      |-> ERASE_INFO.kind != EK_CHIP)
      else $error("chip erase taken in otp mode");
   AST_BUSY_NO_ERASE: assert property (ERASE_REQ |-> !$past(ARRAY_BUSY))
      else $error("erase started over a running cycle");
   AST_ACTIVE_SYNC: assert property (SFDP_ACTIVE
      == $past(SPI_MISO_OE, 2))
      else $error("stream flag not two cycles behind enable");
   // main scenarios reached
   cover property (ERASE_REQ && ERASE_INFO.otp);
   cover property (ERASE_REFUSED);
   cover property ($rose(SFDP_ACTIVE));
   cover property (ARR_OTP_HIT);
endmodule // sfo_properties
bind sfo_top sfo_properties u_props (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST),
   .SPI_SCK(SPI_SCK), .SPI_CS_N(SPI_CS_N), .SPI_MOSI(SPI_MOSI),
   .SPI_MISO(SPI_MISO), .SPI_MISO_OE(SPI_MISO_OE), .ARRAY_BUSY(ARRAY_BUSY),
   .ARR_ADDR(ARR_ADDR), .ARR_OTP_HIT(ARR_OTP_HIT), .OTP_MODE(OTP_MODE),
   .ERASE_REQ(ERASE_REQ), .ERASE_INFO(ERASE_INFO),
   .ERASE_REFUSED(ERASE_REFUSED), .SFDP_ACTIVE(SFDP_ACTIVE));

/* File: sim/sfo_top_tb.sv */
// self-checking bench for the sfdp read and otp erase block
`timescale 1ns/1ns
module sfo_top_tb;
   import sfo_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic busy = 1'b0;
   logic [23:0] addr = 24'h000000;
   logic sck, cs_n, mosi, miso, miso_oe, hit, otp, ereq, eref, active;
   sfo_erase_req_t einfo;
   int mismatches = 0;
   int samples_checked = 0;
   int n_req = 0;
   int n_ref = 0;
   int n_act = 0;
   logic [7:0] rom [16] = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h00, 8'h01,
      8'h00, 8'hFF, 8'h00, 8'h00, 8'h01, 8'h09, 8'h30, 8'h00, 8'h00,
      8'hFF};
   always #2 clk = ~clk;
   sfo_top uut (.SYS_CLK(clk), .SYS_RST(rst), .SPI_SCK(sck), .SPI_CS_N(cs_n),
      .SPI_MOSI(mosi), .SPI_MISO(miso), .SPI_MISO_OE(miso_oe),
      .ARRAY_BUSY(busy), .ARR_ADDR(addr), .ARR_OTP_HIT(hit), .OTP_MODE(otp),
      .ERASE_REQ(ereq), .ERASE_INFO(einfo), .ERASE_REFUSED(eref),
      .SFDP_ACTIVE(active));
   sfo_host_model host (.sck(sck), .cs_n(cs_n), .mosi(mosi), .miso(miso),
      .miso_oe(miso_oe));
   ///////////////////////////////////////////////////////////////
   // erase pulses and cycles of the stream flag counted
   always @(posedge clk) begin
      if (ereq === 1'b1) n_req++;
      if (eref === 1'b1) n_ref++;
      if (active === 1'b1) n_act++;
   end
   // expected table byte; undefined places read all ones
   function automatic logic [7:0] tbl(input logic [23:0] a);
      return (a < 24'h000010) ? rom[a[3:0]] : 8'hFF;
   endfunction
   task automatic chk(input string what, input logic [27:0] exp,
      input logic [27:0] got);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   // whole table from zero and one byte past its end
   task automatic t_table();
      int a0;
      a0 = n_act;
      host.frame(OP_SFDP_READ, 24'h000000, 32, 136);
      chk("output enable seen", 28'h1, {27'h0, host.oe_seen});
      chk("stream flag", 28'h1, {27'h0, n_act != a0});
      for (int i = 0; i < 17; i++)
         chk("table byte", {20'h0, tbl(24'(i))},
            {20'h0, host.rx_q[i]});
   endtask
   // start near the top so the address rolls over to zero
   task automatic t_wrap();
      host.frame(OP_SFDP_READ, 24'hFFFFFE, 32, 32);
      for (int i = 0; i < 4; i++)
         chk("wrap byte", {20'h0, tbl(24'hFFFFFE + 24'(i))},
            {20'h0, host.rx_q[i]});
   endtask
   // deselect in mid byte, output must be released
   task automatic t_abort();
      host.frame(OP_SFDP_READ, 24'h00000B, 32, 12);
      chk("byte before abort", 28'h09, {20'h0, host.rx_q[0]});
      chk("enable after abort", 28'h0, {27'h0, miso_oe});
      chk("data after abort", 28'h0, {27'h0, miso});
   endtask
   // table read and erase while an array cycle runs
   task automatic t_busy();
      int r0;
      int a0;
      r0 = n_req;
      a0 = n_act;
      @(negedge clk) busy = 1'b1;
      host.frame(OP_SFDP_READ, 24'h000000, 32, 16);
      chk("enable while busy", 28'h0, {27'h0, host.oe_seen});
      chk("stream flag while busy", 28'h0, 28'(n_act - a0));
      host.frame(OP_ERASE_4K, 24'h001000, 24, 0);
      chk("erase while busy", 28'h0, 28'(n_req - r0));
      @(negedge clk) busy = 1'b0;
   endtask
   // otp mode, window mapping, erase forms, and exit
   task automatic t_otp();
      logic [7:0] ops [5] = '{8'h52, 8'hD8, 8'hC7, 8'h60, 8'h20};
      logic [23:0] wa [4] = '{24'h0FF000, 24'h0FF1FF, 24'h0FF200, 24'h0FEFFF};
      int r0, f0;
      host.frame(OP_OTP_ENTER, 24'h0, 0, 0);
      chk("otp mode on", 28'h1, {27'h0, otp});
      for (int k = 0; k < 4; k++) begin
         @(negedge clk) addr = wa[k];
         repeat (2) @(negedge clk);
         chk("otp hit", {27'h0, k < 2}, {27'h0, hit});
      end
      for (int k = 0; k < 5; k++) begin
         r0 = n_req;
         f0 = n_ref;
         host.frame(ops[k], 24'h0FF010, 24, 0);
         chk("erase taken", {27'h0, k == 4}, 28'(n_req - r0));
         chk("erase refused", {27'h0, k != 4}, 28'(n_ref - f0));
      end
      chk("otp erase target", {3'h1, 24'h0FF010, 1'b1}, einfo);
      host.frame(OP_WRITE_DISABLE, 24'h0, 0, 0);
      chk("otp mode off", 28'h0, {27'h0, otp});
      @(negedge clk) addr = 24'h0FF000;
      repeat (2) @(negedge clk);
      chk("hit after exit", 28'h0, {27'h0, hit});
      host.frame(OP_ERASE_4K, 24'h0FF010, 24, 0);
      chk("normal erase target", {3'h1, 24'h0FF010, 1'b0}, einfo);
   endtask
   task automatic stop_test();
      if (mismatches == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // main sequence after a 20 cycle reset
   initial begin
      repeat (20) @(negedge clk);
      rst = 1'b0;
      repeat (5) @(negedge clk);
      t_table();
      t_wrap();
      t_abort();
      t_busy();
      t_otp();
      stop_test();
   end
   // hang guard, counted as a mismatch
   initial begin
      #400000;
      mismatches++;
      stop_test();
   end
endmodule // sfo_top_tb

/* File: src/sfo_pkg.sv */
// shared constants and types for the sfdp read and otp erase block
package sfo_pkg;
   // command opcodes
   localparam logic [7:0] OP_SFDP_READ = 8'h5A;
   localparam logic [7:0] OP_OTP_ENTER = 8'h3A;
   localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
   localparam logic [7:0] OP_ERASE_4K = 8'h20;
   localparam logic [7:0] OP_ERASE_32K = 8'h52;
   localparam logic [7:0] OP_ERASE_64K = 8'hD8;
   localparam logic [7:0] OP_ERASE_CHIP_A = 8'hC7;
   localparam logic [7:0] OP_ERASE_CHIP_B = 8'h60;
   // frame bit positions, counted in rising edges
   localparam logic [5:0] BITS_OPCODE = 6'h08;
   localparam logic [5:0] BITS_ADDR_END = 6'h20;
   localparam logic [5:0] BITS_DUMMY_END = 6'h28;
   localparam logic [5:0] CNT_STEP = 6'h01;
   localparam logic [2:0] BIT_STEP = 3'h1;
   localparam logic [2:0] BIT_FIRST = 3'h0;
   localparam logic [23:0] ADDR_STEP = 24'h000001;
   // otp sector placement
   localparam logic [11:0] OTP_SECTOR = 12'h0FF;
   localparam logic [23:0] OTP_START = 24'h0FF000;
   localparam logic [23:0] OTP_END = 24'h0FF1FF;
   // discoverable parameter table
   localparam logic [23:0] SFDP_SIZE = 24'h000010;
   localparam logic [7:0] SFDP_FILL = 8'hFF;
   localparam logic [7:0] SFDP_SIG0 = 8'h53;
   localparam logic [7:0] SFDP_SIG1 = 8'h46;
   localparam logic [7:0] SFDP_SIG2 = 8'h44;
   localparam logic [7:0] SFDP_SIG3 = 8'h50;
   localparam logic [7:0] SFDP_MINOR = 8'h00;
   localparam logic [7:0] SFDP_MAJOR = 8'h01;
   localparam logic [7:0] PARAM_HEADER_COUNT = 8'h00;
   localparam logic [7:0] HDR_ID = 8'h00;
   localparam logic [7:0] HDR_MINOR = 8'h00;
   localparam logic [7:0] HDR_MAJOR = 8'h01;
   localparam logic [7:0] HDR_LEN_DW = 8'h09;
   localparam logic [23:0] PARAM_TABLE_POINTER = 24'h000030;
   localparam logic [7:0] SFDP_ROM [0:15] = '{
      SFDP_SIG0, SFDP_SIG1, SFDP_SIG2, SFDP_SIG3,
      SFDP_MINOR, SFDP_MAJOR, PARAM_HEADER_COUNT, SFDP_FILL,
      HDR_ID, HDR_MINOR, HDR_MAJOR, HDR_LEN_DW,
      PARAM_TABLE_POINTER[7:0], PARAM_TABLE_POINTER[15:8],
      PARAM_TABLE_POINTER[23:16], SFDP_FILL};
   // erase forms handed to the array
   typedef enum logic [2:0] {
      EK_NONE, EK_SECTOR, EK_BLK32, EK_BLK64, EK_CHIP
   } sfo_erase_kind_t;
   typedef struct packed {
      sfo_erase_kind_t kind;
      logic [23:0] addr;
      logic otp;
   } sfo_erase_req_t;
endpackage

/* File: src/sfo_top.sv */
// sfdp read path on the serial link and otp sector erase gating
`timescale 1ns/1ns
// Notes on behaviour
// - in otp mode the otp sector erases only by 4k sector erase
// - otp region maps onto sector 255, addresses 0FF000h to 0FF1FFh
// - host sends opcode, three address bytes msb first, one dummy byte
// - after dummy byte, table byte driven one bit per falling edge
// - any start address; address advances by one per byte
// - address counter wraps to zero and streaming continues
// - chip select high stops output and ends the command
// - table read refused while an array cycle runs
// - bytes 00h to 03h give the signature 53h 46h 44h 50h
// - byte 04h minor revision 00h, byte 05h major revision 01h
// - byte 06h header count 00h; bytes 07h and 0Fh read FFh
// - header id 00h, minor 00h, major 01h at bytes 08h to 0Ah
// - byte 0Bh gives table length of nine words
// - bytes 0Ch to 0Eh give pointer 000030h, low byte first
// - enter otp opcode switches sector 255 to the otp array
// - write disable opcode restores normal sector 255 mapping
module sfo_top
   import sfo_pkg::*;
(
   input wire logic SYS_CLK, // system clock
   input wire logic SYS_RST, // synchronous reset, high
   input wire logic SPI_SCK, // serial clock from host
   input wire logic SPI_CS_N, // chip select, low active
   input wire logic SPI_MOSI, // serial data in
   output logic SPI_MISO, // serial data out
   output logic SPI_MISO_OE, // high while driving data out
   input wire logic ARRAY_BUSY, // array cycle running
   input wire logic [23:0] ARR_ADDR, // array access address
   output logic ARR_OTP_HIT, // access goes to otp array
   output logic OTP_MODE, // otp mode active
   output logic ERASE_REQ, // erase start pulse
   output sfo_erase_req_t ERASE_INFO, // erase form and target
   output logic ERASE_REFUSED, // refused erase pulse
   output logic SFDP_ACTIVE // table stream running
);

   ////////////////////////////////////////////////////////////////////
   // decode helpers
   // table lookup, outside the defined rows reads fill
   function automatic logic [7:0] sfdp_byte(input logic [23:0] a);
      logic [7:0] b;
      b = SFDP_FILL;
      if (a < SFDP_SIZE) begin
         b = SFDP_ROM[a[3:0]];
      end
      return b;
   endfunction

   // erase form of an opcode
   function automatic sfo_erase_kind_t erase_kind(input logic [7:0] op);
      sfo_erase_kind_t k;
      k = EK_NONE;
      case (op)
         OP_ERASE_4K: k = EK_SECTOR;
         OP_ERASE_32K: k = EK_BLK32;
         OP_ERASE_64K: k = EK_BLK64;
         OP_ERASE_CHIP_A: k = EK_CHIP;
         OP_ERASE_CHIP_B: k = EK_CHIP;
         default: k = EK_NONE;
      endcase
      return k;
   endfunction

   // address inside the otp window
   function automatic logic otp_range(input logic [23:0] a);
      return (a >= OTP_START) && (a <= OTP_END);
   endfunction

   ////////////////////////////////////////////////////////////////////
   // system side declarations
   typedef enum logic [1:0] {ST_IDLE, ST_SEL, ST_EXEC} sfo_state_t;
   sfo_state_t state_r;
   sfo_state_t state_nxt;
   logic link_rst_r;
   logic cs_s1_r, cs_s2_r, cs_s3_r;
   logic opt_s1_r, opt_s2_r, opt_s3_r;
   logic adt_s1_r, adt_s2_r, adt_s3_r;
   logic act_s1_r, act_s2_r;
   logic [7:0] op_cap_r;
   logic [23:0] addr_cap_r;
   logic op_seen_r, addr_seen_r;
   logic otp_mode_r;
   logic otp_hit_r;
   logic erase_req_r, erase_ref_r;
   sfo_erase_req_t erase_info_r;

   ////////////////////////////////////////////////////////////////////
   // link side declarations
   logic frame_rst;
   logic [5:0] cnt_r;
   logic [7:0] op_word_r;
   logic [23:0] addr_word_r;
   logic op_tgl_r, addr_tgl_r;
   logic bsy1_r, bsy2_r;
   logic sfdp_go_r, data_ph_r;
   logic [2:0] nb_r;
   logic [23:0] rd_addr_r;
   logic [6:0] sh_r;
   logic miso_r, oe_r;

   ////////////////////////////////////////////////////////////////////
   // link side, rising edge: bits are taken here
   // deselect or system reset clears the frame; constant reset values
   assign frame_rst = SPI_CS_N | link_rst_r;

   wire [7:0] op_shift = {op_word_r[6:0], SPI_MOSI};
   wire op_last = (cnt_r == BITS_OPCODE - CNT_STEP);
   wire addr_last = (cnt_r == BITS_ADDR_END - CNT_STEP);
   wire dummy_last = (cnt_r == BITS_DUMMY_END - CNT_STEP);
   wire in_op = (cnt_r < BITS_OPCODE);
   wire in_addr = !in_op && (cnt_r < BITS_ADDR_END);

   // bit counter, saturates once the dummy byte is done
   always_ff @(posedge SPI_SCK or posedge frame_rst) begin
      if (frame_rst) begin
         cnt_r <= '0;
      end else if (cnt_r < BITS_DUMMY_END) begin
         cnt_r <= cnt_r + CNT_STEP;
      end
   end

   // opcode and address words outlive the frame so the system side
   // can pick them up after chip select rises
   always_ff @(posedge SPI_SCK or posedge link_rst_r) begin
      if (link_rst_r) begin
         op_word_r <= '0;
         addr_word_r <= '0;
      end else begin
         if (in_op) begin
            op_word_r <= op_shift;
         end
         if (in_addr) begin
            addr_word_r <= {addr_word_r[22:0], SPI_MOSI};
         end
      end
   end

   // toggles announce a complete opcode and a complete address
   always_ff @(posedge SPI_SCK or posedge link_rst_r) begin
      if (link_rst_r) begin
         op_tgl_r <= 1'b0;
         addr_tgl_r <= 1'b0;
      end else begin
         op_tgl_r <= op_tgl_r ^ op_last;
         addr_tgl_r <= addr_tgl_r ^ addr_last;
      end
   end

   // busy level into the link clock; seven edges precede the decode
   always_ff @(posedge SPI_SCK or posedge frame_rst) begin
      if (frame_rst) begin
         bsy1_r <= 1'b0;
         bsy2_r <= 1'b0;
      end else begin
         bsy1_r <= ARRAY_BUSY;
         bsy2_r <= bsy1_r;
      end
   end

   // table read accepted only when no array cycle runs
   always_ff @(posedge SPI_SCK or posedge frame_rst) begin
      if (frame_rst) begin
         sfdp_go_r <= 1'b0;
         data_ph_r <= 1'b0;
      end else begin
         if (op_last && op_shift == OP_SFDP_READ && !bsy2_r) begin
            sfdp_go_r <= 1'b1;
         end
         if (dummy_last && sfdp_go_r) begin
            data_ph_r <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // link side, falling edge: data goes out here
   wire [7:0] cur_byte = sfdp_byte(rd_addr_r);
   // byte shifter, msb first; rd address rolls over by plain overflow
   always_ff @(negedge SPI_SCK or posedge frame_rst) begin
      if (frame_rst) begin
         nb_r <= BIT_FIRST;
         rd_addr_r <= '0;
         sh_r <= '0;
         miso_r <= 1'b0;
         oe_r <= 1'b0;
      end else if (!data_ph_r) begin
         rd_addr_r <= addr_word_r;
         nb_r <= BIT_FIRST;
      end else begin
         oe_r <= 1'b1;
         nb_r <= nb_r + BIT_STEP;
         if (nb_r == BIT_FIRST) begin
            miso_r <= cur_byte[7];
            sh_r <= cur_byte[6:0];
            rd_addr_r <= rd_addr_r + ADDR_STEP;
         end else begin
            miso_r <= sh_r[6];
            sh_r <= {sh_r[5:0], 1'b1};
         end
      end
   end

   assign SPI_MISO = miso_r;
   assign SPI_MISO_OE = oe_r;

   ////////////////////////////////////////////////////////////////////
   // system side: crossings
   // held reset for the link domain, released one edge after ours
   always_ff @(posedge SYS_CLK) begin
      link_rst_r <= SYS_RST;
   end
   // level and toggle synchronisers
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         {cs_s1_r, cs_s2_r, cs_s3_r} <= 3'h7;
         {opt_s1_r, opt_s2_r, opt_s3_r} <= 3'h0;
         {adt_s1_r, adt_s2_r, adt_s3_r} <= 3'h0;
         {act_s1_r, act_s2_r} <= 2'h0;
      end else begin
         {cs_s1_r, cs_s2_r, cs_s3_r} <= {SPI_CS_N, cs_s1_r, cs_s2_r};
         {opt_s1_r, opt_s2_r, opt_s3_r} <= {op_tgl_r, opt_s1_r, opt_s2_r};
         {adt_s1_r, adt_s2_r, adt_s3_r} <= {addr_tgl_r, adt_s1_r, adt_s2_r};
         {act_s1_r, act_s2_r} <= {oe_r, act_s1_r};
      end
   end
   wire cs_fall = cs_s3_r && !cs_s2_r;
   wire cs_rise = !cs_s3_r && cs_s2_r;
   wire op_evt = opt_s2_r ^ opt_s3_r;
   wire addr_evt = adt_s2_r ^ adt_s3_r;

   ////////////////////////////////////////////////////////////////////
   // system side: command decode at deselect
   wire exec = (state_r == ST_EXEC);
   wire sfo_erase_kind_t kind = erase_kind(op_cap_r);
   wire is_erase = op_seen_r && (kind != EK_NONE);
   wire sec_otp = addr_cap_r[23:12] == OTP_SECTOR;
   wire b64_otp = addr_cap_r[23:16] == OTP_START[23:16];
   wire b32_otp = addr_cap_r[23:15] == OTP_START[23:15];
   // otp mode protects sector 255 from every form but sector erase
   wire otp_block = otp_mode_r && ((kind == EK_CHIP)
      || (kind == EK_BLK64 && b64_otp)
      || (kind == EK_BLK32 && b32_otp));
   wire has_addr = (kind == EK_CHIP) || addr_seen_r;
   wire erase_ok = is_erase && has_addr && !ARRAY_BUSY && !otp_block;
   wire do_enter = exec && op_seen_r && op_cap_r == OP_OTP_ENTER
      && !ARRAY_BUSY;
   wire do_exit = exec && op_seen_r && op_cap_r == OP_WRITE_DISABLE;

   // frame tracking
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: if (cs_fall) state_nxt = ST_SEL;
         ST_SEL: if (cs_rise) state_nxt = ST_EXEC;
         ST_EXEC: state_nxt = ST_IDLE;
         default: state_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // capture words once their toggle arrives; stable by then
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         op_cap_r <= '0;
         addr_cap_r <= '0;
         op_seen_r <= 1'b0;
         addr_seen_r <= 1'b0;
      end else if (cs_fall) begin
         op_seen_r <= 1'b0;
         addr_seen_r <= 1'b0;
      end else begin
         if (op_evt) begin
            op_cap_r <= op_word_r;
            op_seen_r <= 1'b1;
         end
         if (addr_evt) begin
            addr_cap_r <= addr_word_r;
            addr_seen_r <= 1'b1;
         end
      end
   end

   // otp mode; exit wins only over no event, enter and exit never meet
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         otp_mode_r <= 1'b0;
      end else if (do_enter) begin
         otp_mode_r <= 1'b1;
      end else if (do_exit) begin
         otp_mode_r <= 1'b0;
      end
   end

   // erase hand-off; sector erase in sector 255 targets otp array while otp mode holds
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         erase_req_r <= 1'b0;
         erase_ref_r <= 1'b0;
         erase_info_r <= '0;
      end else begin
         erase_req_r <= exec && erase_ok;
         erase_ref_r <= exec && is_erase && !erase_ok;
         if (exec && erase_ok) begin
            erase_info_r.kind <= kind;
            erase_info_r.addr <= addr_cap_r;
            erase_info_r.otp <= otp_mode_r && sec_otp
               && kind == EK_SECTOR;
         end
      end
   end

   // array access routing while otp mode holds
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         otp_hit_r <= 1'b0;
      end else begin
         otp_hit_r <= otp_mode_r && otp_range(ARR_ADDR);
      end
   end

   assign ARR_OTP_HIT = otp_hit_r;
   assign OTP_MODE = otp_mode_r;
   assign ERASE_REQ = erase_req_r;
   assign ERASE_REFUSED = erase_ref_r;
   assign ERASE_INFO = erase_info_r;
   assign SFDP_ACTIVE = act_s2_r;
endmodule // sfo_top
